// File: common/tcc_pkg.sv
/*
 * Package for the three-channel input capture block: register map, control
 * field layout, mode encodings and carrier structs.
 * Assumes a 32-bit AXI4-Lite register bus; one aligned word per register.
 */
// Notes on behaviour
// - quadrature decoder enabled owns pins, capture idles
// - three channels, three pins, 16-bit captures
// - identical control register per channel
// - bit 6 enables time base reset
// - mode bits 3..0, zero means off
// - 0001 falling edge, 0010 rising edge
// - 0011 every fourth, 0100 every sixteenth rise
// - 0101 period measurement on rising edges
// - 0110 fall-to-rise, 0111 rise-to-fall width
// - 1000 captures on every input change
// - channel one 1111/1110 raise special trigger
// - trigger codes unused on channels two, three
// - special trigger starts converter conversion
// - bits 7,5,4 read zero; reset zero
// - prescaler cleared while mode is off
// - buffer loads, then optional time base clear
// - width modes always clear on starting edge
package tcc_pkg;
    localparam int          NUM_CH        = 3;
    localparam int          CAP_W         = 16;
    localparam logic [7:0]  ADDR_CTRL1    = 8'h00;
    localparam logic [7:0]  ADDR_CTRL2    = 8'h04;
    localparam logic [7:0]  ADDR_CTRL3    = 8'h08;
    localparam logic [7:0]  ADDR_BUF1     = 8'h0C;
    localparam logic [7:0]  ADDR_BUF2     = 8'h10;
    localparam logic [7:0]  ADDR_BUF3     = 8'h14;
    localparam logic [7:0]  ADDR_STATUS   = 8'h18;
    localparam logic [7:0]  ADDR_MASK     = 8'h1C;
    localparam logic [7:0]  ADDR_TIMEBASE = 8'h20;
    localparam int          REN_BIT       = 6;
    localparam int          MODE_LSB      = 0;
    localparam logic [7:0]  CTRL_WMASK    = 8'h4F;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] TB_RESET      = 16'h0000;
    localparam int          ST_CAP_LSB    = 0;
    localparam int          ST_TRIG_BIT   = 3;
    localparam logic [3:0]  STATUS_WMASK  = 4'hF;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    localparam logic [3:0]  PRE4_LAST     = 4'h3;
    localparam logic [3:0]  PRE16_LAST    = 4'hF;

    typedef enum logic [3:0] {
        MODE_OFF   = 4'h0,
        MODE_FALL  = 4'h1,
        MODE_RISE  = 4'h2,
        MODE_RISE4 = 4'h3,
        MODE_RISE16= 4'h4,
        MODE_PER   = 4'h5,
        MODE_PW_FR = 4'h6,
        MODE_PW_RF = 4'h7,
        MODE_CHG   = 4'h8,
        MODE_TRG_F = 4'hE,
        MODE_TRG_R = 4'hF
    } tcc_mode_e;

    typedef struct packed {
        logic       ren;
        logic [3:0] mode;
    } tcc_ctrl_s;

    typedef struct packed {
        logic capture;
        logic clear_tb;
        logic trigger;
    } tcc_event_s;
endpackage

// File: hdl/tcc_capture.sv
/*
 * Three-channel input capture with AXI4-Lite registers, a shared 16-bit time
 * base, per-channel edge prescalers, sticky event status and one interrupt.
 * Assumes capture pins are asynchronous; axi signals are on aclk.
 */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module tcc_capture
#(
    parameter int NUM_CH = tcc_pkg::NUM_CH,
    parameter int CAP_W  = tcc_pkg::CAP_W
)
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      clk_en,
    input  wire logic [2:0]                capture_pins,
    input  wire logic                      quadrature_decoder_en,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic                           converter_start,
    output logic                           irq
);
    localparam int N = NUM_CH;
    localparam int W = CAP_W;

    tcc_pkg::tcc_ctrl_s   ctrl_reg     [N];
    logic [W-1:0]         buf_reg      [N];
    logic [3:0]           pre_reg      [N];
    logic                 pw_arm_reg   [N];
    logic [3:0]           mode_prev_reg[N];
    tcc_pkg::tcc_event_s  ev           [N];
    logic [W-1:0]         tb_reg;
    logic [2:0]           sync1_reg;
    logic [2:0]           sync2_reg;
    logic [2:0]           last_reg;
    logic                 cap_pend_reg [N];
    logic                 clr_pend_reg;
    logic [3:0]           status_reg;
    logic [3:0]           mask_reg;
    logic                 trig_reg;
    logic                 aw_held_reg;
    logic                 w_held_reg;
    logic [7:0]           awaddr_reg;
    logic [31:0]          wdata_reg;
    logic [3:0]           wstrb_reg;
    logic                 do_write;
    logic                 active;
    logic [3:0]           ev_bits;
    logic                 wr_tb;

    // 32-bit read image of a control register, unimplemented bits zero
    function automatic logic [31:0] ctrl_word(input tcc_pkg::tcc_ctrl_s c);
        logic [31:0] v;
        v                                   = 32'h0000_0000;
        v[tcc_pkg::REN_BIT]                 = c.ren;
        v[tcc_pkg::MODE_LSB +: 4]           = c.mode;
        return v;
    endfunction

    // byte-lane merge of a write into an 8-bit control image
    function automatic tcc_pkg::tcc_ctrl_s ctrl_from(input logic [31:0] d, input logic [3:0] s,
                                                     input tcc_pkg::tcc_ctrl_s old);
        logic [7:0]  v;
        logic [31:0] o;
        o = ctrl_word(old);
        v = s[0] ? (d[7:0] & tcc_pkg::CTRL_WMASK) : o[7:0];
        return '{ren: v[tcc_pkg::REN_BIT], mode: v[tcc_pkg::MODE_LSB +: 4]};
    endfunction

    // rising edge of one synchronised pin against its previous sample
    function automatic logic edge_rise(input logic now_v, input logic was_v);
        return now_v && !was_v;
    endfunction

    // falling edge of one synchronised pin against its previous sample
    function automatic logic edge_fall(input logic now_v, input logic was_v);
        return !now_v && was_v;
    endfunction

    // prescaler step: the every-fourth mode wraps after its last count, others wrap at 16
    function automatic logic [3:0] prescale_step(input logic [3:0] mode, input logic [3:0] pre);
        if (mode == tcc_pkg::MODE_RISE4 && pre == tcc_pkg::PRE4_LAST)
            return 4'h0;
        return pre + 4'h1;
    endfunction

    // ports and read packing are sized for three 16-bit channels only
    if (N != 3 || W != 16)
    begin : g_bad_size
        $error("tcc_capture: only three 16-bit channels are supported");
    end

    // pin synchroniser, then last-value register for edge detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= 3'b000;
            sync2_reg <= 3'b000;
            last_reg  <= 3'b000;
        end
        else if (clk_en)
        begin
            sync1_reg <= capture_pins;
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    assign active = !quadrature_decoder_en;

    // per-channel edge decode into capture / clear / trigger events
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            logic rise;
            logic fall;
            rise  = edge_rise(sync2_reg[i], last_reg[i]);
            fall  = edge_fall(sync2_reg[i], last_reg[i]);
            ev[i] = '{capture: 1'b0, clear_tb: 1'b0, trigger: 1'b0};
            if (active)
            begin
                case (ctrl_reg[i].mode)
                    tcc_pkg::MODE_FALL:   ev[i].capture = fall;
                    tcc_pkg::MODE_RISE:   ev[i].capture = rise;
                    tcc_pkg::MODE_RISE4:  ev[i].capture = rise && pre_reg[i] == tcc_pkg::PRE4_LAST;
                    tcc_pkg::MODE_RISE16: ev[i].capture = rise && pre_reg[i] == tcc_pkg::PRE16_LAST;
                    tcc_pkg::MODE_PER:    ev[i].capture = rise;
                    tcc_pkg::MODE_PW_FR:
                    begin
                        ev[i].capture  = rise && pw_arm_reg[i];
                        ev[i].clear_tb = fall;
                    end
                    tcc_pkg::MODE_PW_RF:
                    begin
                        ev[i].capture  = fall && pw_arm_reg[i];
                        ev[i].clear_tb = rise;
                    end
                    tcc_pkg::MODE_CHG:    ev[i].capture = rise || fall;
                    tcc_pkg::MODE_TRG_R:  ev[i].trigger = (i == 0) && rise;
                    tcc_pkg::MODE_TRG_F:  ev[i].trigger = (i == 0) && fall;
                    default:              ev[i].capture = 1'b0;
                endcase
            end
        end
    end

    // prescaler and pulse-width arm per channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < N; i++)
            begin
                pre_reg[i]       <= 4'h0;
                pw_arm_reg[i]    <= 1'b0;
                mode_prev_reg[i] <= 4'h0;
            end
        end
        else if (clk_en)
        begin
            for (int i = 0; i < N; i++)
            begin
                mode_prev_reg[i] <= ctrl_reg[i].mode;
                // only the off code clears the prescaler; other mode changes keep its count
                if (ctrl_reg[i].mode == tcc_pkg::MODE_OFF)
                    pre_reg[i] <= 4'h0;
                else if (active && edge_rise(sync2_reg[i], last_reg[i]))
                    pre_reg[i] <= prescale_step(ctrl_reg[i].mode, pre_reg[i]);
                // a mode change disarms width measurement so a stale start edge is not used
                if (ctrl_reg[i].mode != mode_prev_reg[i])
                    pw_arm_reg[i] <= 1'b0;
                else if (ev[i].clear_tb)
                    pw_arm_reg[i] <= 1'b1;
                else if (ev[i].capture)
                    pw_arm_reg[i] <= 1'b0;
            end
        end
    end

    // capture and clear both one cycle after the event, on the same edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < N; i++)
            begin
                cap_pend_reg[i] <= 1'b0;
                buf_reg[i]      <= 16'h0000;
            end
            clr_pend_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            clr_pend_reg <= 1'b0;
            for (int i = 0; i < N; i++)
            begin
                cap_pend_reg[i] <= ev[i].capture;
                // buffer takes the time base one cycle after the event, before any clear lands
                if (cap_pend_reg[i])
                    buf_reg[i] <= tb_reg;
                if ((ev[i].capture && ctrl_reg[i].ren) || ev[i].clear_tb)
                    clr_pend_reg <= 1'b1;
            end
        end
    end

    // shared free-running time base; a software write wins over clearing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tb_reg <= tcc_pkg::TB_RESET;
        else if (clk_en)
        begin
            if (wr_tb)
                tb_reg <= wdata_reg[W-1:0];
            else if (clr_pend_reg)
                tb_reg <= tcc_pkg::TB_RESET;
            else
                tb_reg <= tb_reg + 16'h0001;
        end
    end

    // special event trigger pulse toward the converter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            trig_reg <= 1'b0;
        else if (clk_en)
            trig_reg <= ev[0].trigger;
    end
    assign converter_start = trig_reg;

    // AXI4-Lite write channel capture
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg;
    assign wr_tb         = do_write && awaddr_reg == tcc_pkg::ADDR_TIMEBASE && wstrb_reg[1:0] == 2'b11;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tcc_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg <= tcc_pkg::ADDR_TIMEBASE && awaddr_reg[1:0] == 2'b00)
                                ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control, mask and status registers
    always_comb
    begin
        for (int i = 0; i < N; i++)
            ev_bits[tcc_pkg::ST_CAP_LSB + i] = cap_pend_reg[i];
        ev_bits[tcc_pkg::ST_TRIG_BIT] = trig_reg;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < N; i++)
                ctrl_reg[i] <= '{ren: 1'b0, mode: tcc_pkg::CTRL_RESET[3:0]};
            mask_reg   <= 4'h0;
            status_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (do_write)
            begin
                for (int i = 0; i < N; i++)
                    if (awaddr_reg == tcc_pkg::ADDR_CTRL1 + 8'(4 * i))
                        ctrl_reg[i] <= ctrl_from(wdata_reg, wstrb_reg, ctrl_reg[i]);
                if (awaddr_reg == tcc_pkg::ADDR_MASK && wstrb_reg[0])
                    mask_reg <= wdata_reg[3:0];
            end
            // set beats write-one-to-clear
            if (do_write && awaddr_reg == tcc_pkg::ADDR_STATUS && wstrb_reg[0])
                status_reg <= (status_reg & ~(wdata_reg[3:0] & tcc_pkg::STATUS_WMASK)) | ev_bits;
            else
                status_reg <= status_reg | ev_bits;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= tcc_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            // read data is registered and stands until rready
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= tcc_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    tcc_pkg::ADDR_CTRL1:    s_axi_rdata <= ctrl_word(ctrl_reg[0]);
                    tcc_pkg::ADDR_CTRL2:    s_axi_rdata <= ctrl_word(ctrl_reg[1]);
                    tcc_pkg::ADDR_CTRL3:    s_axi_rdata <= ctrl_word(ctrl_reg[2]);
                    tcc_pkg::ADDR_BUF1:     s_axi_rdata <= {16'h0000, buf_reg[0]};
                    tcc_pkg::ADDR_BUF2:     s_axi_rdata <= {16'h0000, buf_reg[1]};
                    tcc_pkg::ADDR_BUF3:     s_axi_rdata <= {16'h0000, buf_reg[2]};
                    tcc_pkg::ADDR_STATUS:   s_axi_rdata <= {28'h000_0000, status_reg};
                    tcc_pkg::ADDR_MASK:     s_axi_rdata <= {28'h000_0000, mask_reg};
                    tcc_pkg::ADDR_TIMEBASE: s_axi_rdata <= {16'h0000, tb_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= tcc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: tb/tcc_capture_assertions.sv
/* checker: bus handshakes and trigger pulse of tcc_capture
   assumes one clock domain and a synchronous active-low reset */
`timescale 1ns/1ns
module tcc_capture_assertions
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    input wire logic        quadrature_decoder_en,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        converter_start,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_start_pulse; converter_start && clk_en |=> !converter_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_decoder_quiet; quadrature_decoder_en [*6] |-> !converter_start; endproperty
    a_decoder_quiet: assert property (p_decoder_quiet) else $error("trigger while decoder owns pins");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");
    property p_r_lat; s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
    property p_reset_quiet; $rose(aresetn) |-> !irq && !converter_start; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule
bind tcc_capture tcc_capture_assertions u_tcc_capture_assertions (.*);

// File: tb/tcc_sensor.sv
/* sensor model driving the three capture pins
   assumes its task is entered just after a rising aclk edge */
`timescale 1ns/1ns
module tcc_sensor
(
    input  wire logic       aclk,
    output logic [2:0]      pins
);
    initial pins = 3'h0;
    // levels move only on core clock edges, so the time base stays synchronous
    task automatic set_pin(input int ch, input logic v, input int gap);
        pins[ch] <= v;
        repeat (gap) @(posedge aclk);
    endtask
endmodule

// File: tb/tcc_capture_tb.sv
/* bench for tcc_capture: AXI4-Lite master tasks, tcc_sensor on the pins
   assumes the package register map and a 250 MHz aclk */
`timescale 1ns/1ns
module tcc_capture_tb;
    localparam logic [1:0] OK = tcc_pkg::RESP_OKAY;
    localparam logic [7:0] C1 = tcc_pkg::ADDR_CTRL1, C2 = tcc_pkg::ADDR_CTRL2, C3 = tcc_pkg::ADDR_CTRL3;
    localparam logic [7:0] B1 = tcc_pkg::ADDR_BUF1, B2 = tcc_pkg::ADDR_BUF2, B3 = tcc_pkg::ADDR_BUF3;
    localparam logic [7:0] ST = tcc_pkg::ADDR_STATUS, MK = tcc_pkg::ADDR_MASK;
    logic        aclk = 1'b0, aresetn = 1'b0, qd_en = 1'b0, ce = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic        awr, wr_rdy, bv, arr, rv, cstart, irq;
    logic [7:0]  awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0]  br, rr;
    logic [2:0]  pins;
    int          bad_count = 0, total_checks = 0, starts = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (cstart === 1'b1) starts <= starts + 1;
    tcc_sensor u_tcc_sensor (.aclk(aclk), .pins(pins));
    tcc_capture u_tcc_capture
    (
        .aclk(aclk), .aresetn(aresetn), .clk_en(ce), .capture_pins(pins), .quadrature_decoder_en(qd_en),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .converter_start(cstart), .irq(irq)
    );
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one transfer; ready is looked at mid-cycle, so it equals what the next rising edge samples
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e,
                       output logic [31:0] q);
        logic ka, kw, kr, tb;
        logic [1:0] r;
        tb = 1'b0;
        @(posedge aclk);
        awa <= a;
        ara <= a;
        wd <= d;
        awv <= w;
        wv <= w;
        bre <= w;
        arv <= !w;
        rre <= !w;
        while (!tb)
        begin
            @(negedge aclk);
            ka = awr;
            kw = wr_rdy;
            kr = arr;
            tb = w ? bv : rv;
            r = w ? br : rr;
            q = rdat;
            @(posedge aclk);
            awv <= awv & !ka;
            wv <= wv & !kw;
            arv <= arv & !kr;
        end
        bre <= 1'b0;
        rre <= 1'b0;
        check("response", {29'h0, 1'b1, e}, {29'h0, tb, r});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, OK, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, OK, q);
    endtask
    task automatic stat(input string nm, input logic [3:0] e);
        logic [31:0] q;
        rd(ST, q);
        check(nm, {28'h0, e}, q);
        wr(ST, 32'hF);
    endtask
    task automatic pin(input int c, input logic v);
        u_tcc_sensor.set_pin(c, v, 10);
    endtask
    task automatic ck_irq(input logic e);
        @(negedge aclk);
        check("irq", {31'h0, e}, {31'h0, irq});
        @(posedge aclk);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        for (int i = 0; i < 3; i++)
        begin
            rd(C1 + 8'(4 * i), q);
            check("ctrl reset", 32'h0, q);
            wr(C1 + 8'(4 * i), 32'hFF);
            rd(C1 + 8'(4 * i), q);
            check("ctrl bits", 32'h4F, q);
            wr(C1 + 8'(4 * i), 32'h0);
        end
        bus(1'b1, 8'h24, 32'h1, tcc_pkg::RESP_SLVERR, q);
        bus(1'b0, 8'h24, 32'h0, tcc_pkg::RESP_SLVERR, q);
        check("unmapped", 32'h0, q);
    endtask
    task automatic t_edge;
        pin(1, 1'b1);
        pin(1, 1'b0);
        stat("off", 4'h0);
        wr(C1, 32'h1);
        wr(C3, 32'h2);
        pin(0, 1'b1);
        pin(2, 1'b1);
        stat("rise", 4'h4);
        pin(0, 1'b0);
        pin(2, 1'b0);
        stat("fall", 4'h1);
        wr(C1, 32'h0);
        wr(C3, 32'h0);
    endtask
    task automatic t_every(input logic [31:0] m, input int n);
        wr(C2, m);
        pin(1, 1'b1);
        pin(1, 1'b0);
        wr(C2, 32'h0);
        wr(ST, 32'hF);
        wr(C2, m);
        for (int i = 1; i <= n; i++)
        begin
            pin(1, 1'b1);
            pin(1, 1'b0);
            stat("prescaled", (i == n) ? 4'h2 : 4'h0);
        end
        wr(C2, 32'h0);
    endtask
    task automatic t_stamp;
        logic [31:0] b2, b3;
        wr(C2, 32'h5);
        wr(C3, 32'h2);
        u_tcc_sensor.set_pin(1, 1'b1, 12);
        pin(2, 1'b1);
        rd(B2, b2);
        rd(B3, b3);
        check("stamp gap", 32'hC, (b3 - b2) & 32'hFFFF);
        wr(C2, 32'h45);
        pin(1, 1'b0);
        pin(2, 1'b0);
        u_tcc_sensor.set_pin(1, 1'b1, 12);
        pin(2, 1'b1);
        rd(B3, b3);
        check("stamp after clear", 32'h1, b3 >= 10 && b3 <= 13);
        pin(1, 1'b0);
        pin(2, 1'b0);
        wr(C2, 32'h0);
        wr(C3, 32'h0);
        wr(ST, 32'hF);
    endtask
    task automatic t_width;
        logic [31:0] b;
        wr(C1, 32'h7);
        u_tcc_sensor.set_pin(0, 1'b1, 20);
        pin(0, 1'b0);
        rd(B1, b);
        check("rise to fall", 32'h1, b >= 18 && b <= 21);
        wr(C1, 32'h0);
        pin(0, 1'b1);
        wr(C1, 32'h6);
        u_tcc_sensor.set_pin(0, 1'b0, 20);
        pin(0, 1'b1);
        rd(B1, b);
        check("fall to rise", 32'h1, b >= 18 && b <= 21);
        wr(C1, 32'h0);
        pin(0, 1'b0);
        wr(ST, 32'hF);
    endtask
    task automatic t_change;
        wr(C3, 32'h8);
        pin(2, 1'b1);
        stat("change rise", 4'h4);
        pin(2, 1'b0);
        stat("change fall", 4'h4);
        wr(C3, 32'h0);
    endtask
    task automatic t_trig;
        logic [31:0] q;
        int s;
        s = starts;
        wr(C1, 32'hF);
        pin(0, 1'b1);
        wr(C1, 32'h0);
        wr(C1, 32'hE);
        pin(0, 1'b0);
        check("trigger pulses", s + 2, starts);
        rd(ST, q);
        check("trigger flag", 32'h1, q[3]);
        wr(C1, 32'h0);
        wr(ST, 32'hF);
        wr(C2, 32'hF);
        pin(1, 1'b1);
        pin(1, 1'b0);
        stat("unused code", 4'h0);
        check("no trigger", s + 2, starts);
        wr(C2, 32'h0);
    endtask
    task automatic t_qd;
        int s;
        s = starts;
        qd_en <= 1'b1;
        wr(C1, 32'h2);
        pin(0, 1'b1);
        stat("decoder owns pins", 4'h0);
        wr(C1, 32'hE);
        pin(0, 1'b0);
        check("decoder blocks trigger", s, starts);
        wr(C1, 32'h0);
        qd_en <= 1'b0;
    endtask
    task automatic t_irq;
        wr(MK, 32'h1);
        wr(C1, 32'h2);
        pin(0, 1'b1);
        ck_irq(1'b1);
        wr(MK, 32'h0);
        ck_irq(1'b0);
        wr(MK, 32'h1);
        ck_irq(1'b1);
        wr(ST, 32'h1);
        ck_irq(1'b0);
        pin(0, 1'b0);
        wr(C1, 32'h0);
    endtask
    // time base read, 20 frozen edges, read again: only the three live edges count
    task automatic t_freeze;
        logic [31:0] a, b;
        rd(tcc_pkg::ADDR_TIMEBASE, a);
        ce <= 1'b0;
        repeat (20) @(posedge aclk);
        ce <= 1'b1;
        rd(tcc_pkg::ADDR_TIMEBASE, b);
        check("frozen time base", 32'h3, (b - a) & 32'hFFFF);
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_edge();
        t_every(32'h3, 4);
        t_every(32'h4, 16);
        t_stamp();
        t_width();
        t_change();
        t_trig();
        t_qd();
        t_irq();
        t_freeze();
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        wrap_up();
    end
endmodule
